// file: config_word_decode_tb_top.sv
// self-checking bench for the configuration word decoder
// assumes the package and the programmer model are compiled first
`timescale 1ns/10ps
module config_word_decode_tb_top
    import cwd_pkg::*;
;
    localparam int PLEN = 20;
    localparam logic [13:0] WORDS [5] = '{14'h3fff, 14'h3ff7, 14'h3ffa, 14'h0005, 14'h1230};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [13:0] nv_word = 14'h3fff;
    logic wdt_rc_tick = 1'b0;
    logic wdt_clear = 1'b0;
    logic ext_reset = 1'b0;
    logic irq_wake = 1'b0;
    logic sleep_req = 1'b0;
    logic prog_mode;
    cwd_prog_req_t prog_req;
    logic [13:0] pmem_rdata;
    logic [13:0] prog_rdata;
    logic prog_rvalid, wdt_timeout, fuses_ready, code_protect_on, powerup_delay_timer_enabled, wdt_enabled;
    logic ext_clock_accept, core_hold, cpu_reset, sleeping, wake_pulse;
    logic [3:0] osc_mode_flags;
    cwd_fuses_t fuses;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    cwd_top #(.POWERUP_DELAY_TIMER_LEN(PLEN)) dut (.clock(clock), .rst(rst), .ce(ce), .nv_word(nv_word),
        .prog_mode(prog_mode), .prog_req(prog_req), .pmem_rdata(pmem_rdata), .prog_rdata(prog_rdata),
        .prog_rvalid(prog_rvalid), .wdt_rc_tick(wdt_rc_tick), .wdt_clear(wdt_clear),
        .wdt_timeout(wdt_timeout), .ext_reset(ext_reset), .irq_wake(irq_wake), .sleep_req(sleep_req),
        .fuses(fuses), .fuses_ready(fuses_ready), .code_protect_on(code_protect_on),
        .powerup_delay_timer_enabled(powerup_delay_timer_enabled), .wdt_enabled(wdt_enabled), .ext_clock_accept(ext_clock_accept),
        .osc_mode_flags(osc_mode_flags), .core_hold(core_hold), .cpu_reset(cpu_reset),
        .sleeping(sleeping), .wake_pulse(wake_pulse));

    cwd_prog_model prog (.clock(clock), .prog_mode(prog_mode), .req(prog_req),
        .pmem_rdata(pmem_rdata), .rdata(prog_rdata), .rvalid(prog_rvalid));

    // ==========================================
    // clock and hang guard
    always #5 clock = ~clock;

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            num_errors++;
            results();
        end
    end

    // ==========================================
    // comparison and sequencing helpers
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task rng(input int n, input int lo, input int hi);
        check(16'((n >= lo) && (n <= hi)), 16'h0001);
    endtask

    // counts falling edges until the core is released; the bound keeps a stuck hold finite
    task wait_run(output int n);
        n = 0;
        while (core_hold !== 1'b0 && n < 3000)
        begin
            @(negedge clock);
            n++;
        end
    endtask

    task automatic strobe(ref logic s);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask

    task start(input logic [13:0] w, output int n);
        @(negedge clock);
        rst = 1'b1;
        nv_word = w;
        repeat (2) @(negedge clock);
        check(16'(fuses), 16'(FUSES_ERASED));
        check(16'({fuses_ready, code_protect_on, cpu_reset}), 16'h0003);
        rst = 1'b0;
        wait_run(n);
    endtask

    task results;
        $display("errors %0d, checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================
    // one pass per stored word; the table covers all four clock modes
    // 3ffa picks high speed mode, the pick for a fast resonator
    initial
    begin
        logic [13:0] w, q;
        logic v, xtal, prot, wk;
        int n, t, base;
        foreach (WORDS[i])
        begin
            w = WORDS[i];
            xtal = (w[1:0] != 2'h3);
            prot = (w[13:4] != CP_DISABLED);
            base = xtal ? 1024 : 0;
            start(w, n);
            rng(n, base + (w[3] ? 0 : PLEN) + 2, base + (w[3] ? 0 : PLEN) + 6);
            check(16'({fuses_ready, fuses}), 16'({1'b1, w}));
            check(16'(code_protect_on), 16'(prot));
            check(16'(powerup_delay_timer_enabled), 16'(!w[3]));
            check(16'(wdt_enabled), 16'(w[2]));
            check(16'(osc_mode_flags), 16'(4'h1 << w[1:0]));
            check(16'(ext_clock_accept), 16'(xtal));
            nv_word = ~w;
            repeat (4) @(negedge clock);
            check(16'(fuses), 16'(w));
            prog.access(1'b0, CFG_WORD_ADDR, 14'h0000, 1'b0, v, q);
            check(16'(v), 16'h0000);
            prog.access(1'b1, CFG_WORD_ADDR, 14'h0000, 1'b0, v, q);
            check(16'({v, q}), 16'({1'b1, w}));
            prog.access(1'b1, 14'h2001, 14'h0000, 1'b0, v, q);
            check(16'(q), 16'h0000);
            prog.access(1'b1, 14'h0010, 14'h0000, 1'b0, v, q);
            check(16'(q), prot ? 16'h0000 : 16'h086f);
            prog.access(1'b1, CFG_WORD_ADDR, ~w, 1'b1, v, q);
            prog.access(1'b0, CFG_WORD_ADDR, 14'h0000, 1'b1, v, q);
            prog.access(1'b1, CFG_WORD_ADDR, 14'h0000, 1'b0, v, q);
            check(16'(q), {2'b00, ~w});
            check(16'(fuses), 16'(w));
            // a pin reset skips the power-up delay
            strobe(ext_reset);
            check(16'(cpu_reset), 16'h0001);
            wait_run(n);
            rng(n, xtal ? 1020 : 0, base + 10);
            // with the enable low a reset request must leave all state frozen
            ce = 1'b0;
            strobe(ext_reset);
            check(16'({cpu_reset, core_hold}), 16'h0000);
            ce = 1'b1;
            strobe(sleep_req);
            check(16'(sleeping), 16'h0001);
            strobe(irq_wake);
            check(16'({wake_pulse, cpu_reset}), 16'h0002);
            wait_run(n);
            check(16'(sleeping), 16'h0000);
            // watchdog in sleep: a clear mid-count restarts the 19 ticks
            strobe(sleep_req);
            t = 0;
            wk = 1'b0;
            for (int k = 1; k <= 32; k++)
            begin
                wdt_rc_tick = (k <= 29);
                wdt_clear = (k == 10);
                @(negedge clock);
                if (wdt_timeout === 1'b1 && t == 0)
                    t = k;
                if (wake_pulse === 1'b1)
                    wk = 1'b1;
            end
            wdt_rc_tick = 1'b0;
            wdt_clear = 1'b0;
            if (w[2])
                rng(t, 29, 30);
            else
                check(16'(t), 16'h0000);
            check(16'(wk), 16'(w[2]));
            wait_run(n);
            if (sleeping !== 1'b1)
                strobe(sleep_req);
            strobe(ext_reset);
            check(16'({cpu_reset, wake_pulse}), 16'h0002);
            wait_run(n);
        end
        results();
    end
endmodule

// file: cwd_pkg.sv
// constants and types shared by the configuration word decoder
// assumes one clock domain at 100 MHz and a synchronous reset
package cwd_pkg;

    // ==========================================
    // addresses and layout of the configuration word
    localparam logic [13:0] CFG_WORD_ADDR = 14'h2007;
    localparam logic [13:0] TEST_SPACE_LO = 14'h2000;
    localparam logic [13:0] TEST_SPACE_HI = 14'h3fff;
    localparam logic [13:0] CFG_ERASED = 14'h3fff;
    localparam int CP_HI = 13;
    localparam int CP_LO = 4;
    localparam int POWERUP_DELAY_ENABLE_N_POS = 3;
    localparam int WATCHDOG_ENABLE_FUSE_POS = 2;
    localparam int OSC_HI = 1;
    localparam int OSC_LO = 0;
    localparam logic [9:0] CP_DISABLED = 10'h3ff;

    // ==========================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int POWERUP_DELAY_TIMER_TIME_MS = 72;
    localparam int POWERUP_DELAY_TIMER_CYCLES = POWERUP_DELAY_TIMER_TIME_MS * 1000000 / CLK_PERIOD_NS;
    localparam int OST_CYCLES = 1024;
    localparam int CNT_W = 23;
    localparam logic [CNT_W-1:0] OST_LAST = 23'h0003ff;
    localparam logic [7:0] WDT_TICK_LIMIT = 8'h12;

    // ==========================================
    // types
    typedef enum logic [1:0]
    {
        low_power_crystal_mode = 2'h0,
        crystal_resonator_mode = 2'h1,
        high_speed_crystal_mode = 2'h2,
        resistor_capacitor_mode = 2'h3
    } cwd_osc_mode_t;

    typedef struct packed
    {
        logic [9:0] code_protect_field;
        logic powerup_delay_enable_n;
        logic watchdog_enable_fuse;
        cwd_osc_mode_t osc_mode_select;
    } cwd_fuses_t;

    localparam cwd_fuses_t FUSES_ERASED = cwd_fuses_t'(CFG_ERASED);

    typedef struct packed
    {
        logic [13:0] addr;
        logic [13:0] wdata;
        logic wr;
        logic rd;
    } cwd_prog_req_t;

    typedef enum logic [4:0]
    {
        hold_start = 5'h01,
        hold_powerup_delay_timer = 5'h02,
        hold_ost = 5'h04,
        hold_run = 5'h08,
        hold_sleep = 5'h10
    } cwd_hold_state_t;

    typedef struct packed
    {
        cwd_hold_state_t st;
        logic [CNT_W-1:0] cnt;
        logic waking;
        logic core_hold;
        logic cpu_reset;
        logic sleeping;
        logic wake_pulse;
    } cwd_hold_regs_t;

    typedef struct packed
    {
        logic [13:0] word;
        logic [13:0] rdata;
        logic rvalid;
    } cwd_prog_regs_t;

endpackage

// file: cwd_prog_model.sv
// programmer model: drives requests and serves the program array
// assumes the bench calls access and that the clock runs free
`timescale 1ns/10ps
module cwd_prog_model
    import cwd_pkg::*;
(
    // clock
    input wire logic clock,
    // requests towards the block
    output logic prog_mode,
    output cwd_prog_req_t req,
    output logic [13:0] pmem_rdata,
    // answers from the block
    input wire logic [13:0] rdata,
    input wire logic rvalid
);
    // ==========================================
    // program array: a pattern that follows the address, so a stale read shows
    assign pmem_rdata = {req.addr[6:0], ~req.addr[6:0]};

    initial
    begin
        prog_mode = 1'b0;
        req = '{addr: 14'h0000, wdata: 14'h0000, wr: 1'b0, rd: 1'b0};
    end

    // ==========================================
    // one request held over one rising edge, answer taken at the next falling edge
    // the test space is only opened with prog_mode high
    task automatic access(input logic mode, input logic [13:0] a, input logic [13:0] d,
        input logic w, output logic v, output logic [13:0] q);
        @(negedge clock);
        prog_mode = mode;
        req = '{addr: a, wdata: d, wr: w, rd: ~w};
        @(negedge clock);
        v = rvalid;
        q = rdata;
        // released lines show the inverse so nothing stale can pass
        req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
        prog_mode = 1'b0;
    endtask
endmodule

// file: cwd_prog_port.sv
// programmer access to the configuration word and the protected array
// assumes pmem_rdata follows req.addr within the same cycle
`timescale 1ns/10ps
module cwd_prog_port
    import cwd_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // word source and protection
    input wire logic load,
    input wire logic [13:0] nv_word,
    input wire logic code_protect_on,
    // programmer side
    input wire logic prog_mode,
    input wire cwd_prog_req_t req,
    input wire logic [13:0] pmem_rdata,
    output logic [13:0] rdata,
    output logic rvalid
);

    cwd_prog_regs_t r;
    cwd_prog_regs_t next_r;
    logic in_test;

    assign in_test = (req.addr >= TEST_SPACE_LO) && (req.addr <= TEST_SPACE_HI);

    // ==========================================
    // access decode
    always_comb
    begin
        next_r = r;
        next_r.rvalid = 1'b0;
        if (load)
        begin
            next_r.word = nv_word;
        end
        else if (prog_mode && req.wr && req.addr == CFG_WORD_ADDR)
        begin
            next_r.word = req.wdata;
        end
        if (prog_mode && req.rd)
        begin
            next_r.rvalid = 1'b1;
            if (req.addr == CFG_WORD_ADDR)
                next_r.rdata = r.word;
            else if (in_test)
                next_r.rdata = 14'h0000;
            else if (code_protect_on)
                next_r.rdata = 14'h0000;
            else
                next_r.rdata = pmem_rdata;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            r <= '{word: CFG_ERASED, rdata: 14'h0000, rvalid: 1'b0};
        end
        else if (ce)
        begin
            r <= next_r;
        end
    end

    assign rdata = r.rdata;
    assign rvalid = r.rvalid;

    // ==========================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_prog_gate_off: assert property (ce && !prog_mode |=> !rvalid)
        else $error("read answered outside programming mode");
    a_cfg_read_back: assert property (ce && prog_mode && req.rd && req.addr == CFG_WORD_ADDR
        |=> rvalid && rdata == $past(r.word))
        else $error("configuration word not returned");
    a_protect_read_zero: assert property (ce && prog_mode && req.rd && req.addr < TEST_SPACE_LO
        && code_protect_on |=> rvalid && rdata == 14'h0000)
        else $error("protected memory leaked");

endmodule

// file: cwd_reset_hold.sv
// reset holding, start-up delays and sleep/wake sequencing
// assumes its inputs are synchronous to clock
`timescale 1ns/10ps
module cwd_reset_hold
    import cwd_pkg::*;
#(
    parameter int POWERUP_DELAY_TIMER_LEN = POWERUP_DELAY_TIMER_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // configuration
    input wire logic fuses_valid,
    input wire logic powerup_delay_timer_on,
    input wire logic crystal_mode,
    // reset and wake sources
    input wire logic ext_reset,
    input wire logic wdt_timeout,
    input wire logic irq_wake,
    input wire logic sleep_req,
    // status
    output logic core_hold,
    output logic cpu_reset,
    output logic sleeping,
    output logic wake_pulse
);

    localparam logic [CNT_W-1:0] POWERUP_DELAY_TIMER_LAST = CNT_W'(POWERUP_DELAY_TIMER_LEN - 1);

    cwd_hold_regs_t r;
    cwd_hold_regs_t next_r;
    logic [CNT_W-1:0] ost_len;

    // rc mode has no crystal to wait for, so the hold is one cycle
    assign ost_len = crystal_mode ? OST_LAST : '0;

    // ==========================================
    // sequencing
    always_comb
    begin
        next_r = r;
        next_r.wake_pulse = 1'b0;
        case (r.st)
            hold_start:
            begin
                if (fuses_valid)
                begin
                    next_r.st = powerup_delay_timer_on ? hold_powerup_delay_timer : hold_ost;
                    next_r.cnt = powerup_delay_timer_on ? POWERUP_DELAY_TIMER_LAST : ost_len;
                end
            end
            hold_powerup_delay_timer:
            begin
                if (r.cnt == '0)
                begin
                    next_r.st = hold_ost;
                    next_r.cnt = ost_len;
                end
                else
                    next_r.cnt = r.cnt - 1'b1;
            end
            hold_ost:
            begin
                if (ext_reset)
                    next_r.waking = 1'b0;
                if (r.cnt == '0)
                begin
                    next_r.st = hold_run;
                    next_r.waking = 1'b0;
                end
                else
                    next_r.cnt = r.cnt - 1'b1;
            end
            hold_run:
            begin
                // later resets skip the power-up delay
                if (ext_reset || wdt_timeout)
                begin
                    next_r.st = hold_ost;
                    next_r.cnt = ost_len;
                end
                else if (sleep_req)
                    next_r.st = hold_sleep;
            end
            hold_sleep:
            begin
                if (ext_reset || wdt_timeout || irq_wake)
                begin
                    next_r.st = hold_ost;
                    next_r.cnt = ost_len;
                    next_r.waking = !ext_reset;
                    next_r.wake_pulse = !ext_reset;
                end
            end
            default:
                next_r.st = hold_start;
        endcase
        next_r.core_hold = next_r.st != hold_run && next_r.st != hold_sleep;
        next_r.cpu_reset = next_r.core_hold && !next_r.waking;
        next_r.sleeping = next_r.st == hold_sleep;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            r <= '{st: hold_start, cnt: '0, waking: 1'b0, core_hold: 1'b1,
                cpu_reset: 1'b1, sleeping: 1'b0, wake_pulse: 1'b0};
        end
        else if (ce)
        begin
            r <= next_r;
        end
    end

    assign core_hold = r.core_hold;
    assign cpu_reset = r.cpu_reset;
    assign sleeping = r.sleeping;
    assign wake_pulse = r.wake_pulse;

    // ==========================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_asleep;
        r.st == hold_sleep;
    endsequence
    sequence s_wake_event;
        ce && (wdt_timeout || irq_wake) && !ext_reset;
    endsequence

    a_sleep_wake_up: assert property (s_asleep ##0 s_wake_event
        |=> wake_pulse && core_hold && !cpu_reset)
        else $error("no wake-up from sleep");
    a_powerup_delay_timer_start_len: assert property (r.st == hold_start && ce && fuses_valid && powerup_delay_timer_on
        |=> r.st == hold_powerup_delay_timer && r.cnt == POWERUP_DELAY_TIMER_LAST)
        else $error("power-up delay not loaded");
    a_reset_skips_powerup_delay_timer: assert property (r.st == hold_run && ce && ext_reset
        |=> r.st == hold_ost && cpu_reset)
        else $error("later reset took wrong path");
    a_ost_holds_core: assert property (ce && r.st == hold_ost && r.cnt != '0
        |=> core_hold && r.cnt == $past(r.cnt) - 1'b1)
        else $error("core released before oscillator settled");

endmodule

// file: cwd_top.sv
// configuration word decoder: latches the fuse word, decodes its fields,
// runs the watchdog and sequences reset holding and sleep
// assumes nv_word shows the stored word from reset onward and that
// wdt_rc_tick is a one-cycle pulse per period of the watchdog rc oscillator
`timescale 1ns/10ps
module cwd_top
    import cwd_pkg::*;
#(
    parameter int POWERUP_DELAY_TIMER_LEN = POWERUP_DELAY_TIMER_CYCLES
)
(
    // clock, reset and enable
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // stored configuration word
    input wire logic [13:0] nv_word,
    // programmer access
    input wire logic prog_mode,
    input wire cwd_prog_req_t prog_req,
    input wire logic [13:0] pmem_rdata,
    output logic [13:0] prog_rdata,
    output logic prog_rvalid,
    // watchdog
    input wire logic wdt_rc_tick,
    input wire logic wdt_clear,
    output logic wdt_timeout,
    // reset and wake sources
    input wire logic ext_reset,
    input wire logic irq_wake,
    input wire logic sleep_req,
    // decoded configuration
    output cwd_fuses_t fuses,
    output logic fuses_ready,
    output logic code_protect_on,
    output logic powerup_delay_timer_enabled,
    output logic wdt_enabled,
    output logic ext_clock_accept,
    output logic [3:0] osc_mode_flags,
    // core control
    output logic core_hold,
    output logic cpu_reset,
    output logic sleeping,
    output logic wake_pulse
);

    typedef struct packed
    {
        cwd_fuses_t fuses;
        logic fuse_ok;
        logic fuses_valid;
        logic code_protect_on;
        logic powerup_delay_timer_enabled;
        logic wdt_enabled;
        logic ext_clock_accept;
        logic [3:0] osc_flags;
        logic [7:0] wdt_cnt;
        logic wdt_timeout;
    } cwd_top_regs_t;

    cwd_top_regs_t r;
    cwd_top_regs_t next_r;
    cwd_fuses_t fuse_src;
    logic [3:0] mode_hit;
    logic hold_cpu_reset;

    // ==========================================
    // fuse decode
    function automatic cwd_fuses_t decode_word(input logic [13:0] w);
        cwd_fuses_t f;
        f.code_protect_field = w[CP_HI:CP_LO];
        f.powerup_delay_enable_n = w[POWERUP_DELAY_ENABLE_N_POS];
        f.watchdog_enable_fuse = w[WATCHDOG_ENABLE_FUSE_POS];
        f.osc_mode_select = cwd_osc_mode_t'(w[OSC_HI:OSC_LO]);
        return f;
    endfunction

    // the word is sampled once; later programming only takes effect
    // after the next reset, so no option can move under running code
    assign fuse_src = r.fuse_ok ? r.fuses : decode_word(nv_word);

    for (genvar m = 0; m < 4; m++)
    begin : g_mode
        assign mode_hit[m] = fuse_src.osc_mode_select == cwd_osc_mode_t'(2'(m));
    end

    // ==========================================
    // state update
    always_comb
    begin
        next_r = r;
        next_r.fuses_valid = 1'b0;
        next_r.wdt_timeout = 1'b0;
        // the first enabled cycle after reset copies the stored word
        if (!r.fuse_ok)
        begin
            next_r.fuses = fuse_src;
            next_r.fuse_ok = 1'b1;
            next_r.fuses_valid = 1'b1;
        end
        // any pattern short of all ones keeps the array locked
        next_r.code_protect_on = fuse_src.code_protect_field != CP_DISABLED;
        next_r.powerup_delay_timer_enabled = !fuse_src.powerup_delay_enable_n;
        next_r.wdt_enabled = fuse_src.watchdog_enable_fuse;
        next_r.ext_clock_accept = fuse_src.osc_mode_select != resistor_capacitor_mode;
        next_r.osc_flags = mode_hit;

        // watchdog: there is deliberately no run-time disable input
        if (!r.wdt_enabled || wdt_clear || hold_cpu_reset)
        begin
            next_r.wdt_cnt = 8'h00;
        end
        else if (wdt_rc_tick)
        begin
            if (r.wdt_cnt == WDT_TICK_LIMIT)
            begin
                next_r.wdt_cnt = 8'h00;
                next_r.wdt_timeout = 1'b1;
            end
            else
            begin
                next_r.wdt_cnt = r.wdt_cnt + 8'h01;
            end
        end
    end

    // before the word is read every option sits on its safe, locked side
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            r.fuses <= FUSES_ERASED;
            r.fuse_ok <= 1'b0;
            r.fuses_valid <= 1'b0;
            r.code_protect_on <= 1'b1;
            r.powerup_delay_timer_enabled <= 1'b0;
            r.wdt_enabled <= 1'b0;
            r.ext_clock_accept <= 1'b0;
            r.osc_flags <= 4'h0;
            r.wdt_cnt <= 8'h00;
            r.wdt_timeout <= 1'b0;
        end
        else if (ce)
        begin
            r <= next_r;
        end
    end

    // ==========================================
    // submodules
    cwd_prog_port u_prog
    (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .load(!r.fuse_ok),
        .nv_word(nv_word),
        .code_protect_on(r.code_protect_on),
        .prog_mode(prog_mode),
        .req(prog_req),
        .pmem_rdata(pmem_rdata),
        .rdata(prog_rdata),
        .rvalid(prog_rvalid)
    );

    // the sequencer sees registered flags, which settle on the same edge
    // that registers its start strobe
    cwd_reset_hold #(
        .POWERUP_DELAY_TIMER_LEN(POWERUP_DELAY_TIMER_LEN)
    ) u_hold
    (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .fuses_valid(r.fuses_valid),
        .powerup_delay_timer_on(r.powerup_delay_timer_enabled),
        .crystal_mode(r.ext_clock_accept),
        .ext_reset(ext_reset),
        .wdt_timeout(r.wdt_timeout),
        .irq_wake(irq_wake),
        .sleep_req(sleep_req),
        .core_hold(core_hold),
        .cpu_reset(hold_cpu_reset),
        .sleeping(sleeping),
        .wake_pulse(wake_pulse)
    );

    // ==========================================
    // outputs
    // every output is a register here or in a submodule
    assign cpu_reset = hold_cpu_reset;
    assign fuses = r.fuses;
    assign fuses_ready = r.fuse_ok;
    assign code_protect_on = r.code_protect_on;
    assign powerup_delay_timer_enabled = r.powerup_delay_timer_enabled;
    assign wdt_enabled = r.wdt_enabled;
    assign ext_clock_accept = r.ext_clock_accept;
    assign osc_mode_flags = r.osc_flags;
    assign wdt_timeout = r.wdt_timeout;

    // ==========================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_wdt_at_limit;
        ce && r.wdt_enabled && !wdt_clear && !hold_cpu_reset && wdt_rc_tick;
    endsequence

    a_fuse_latch_src: assert property (ce && !r.fuse_ok |=> 14'(r.fuses) == $past(nv_word))
        else $error("fuses differ from stored word");
    a_fuse_frozen: assert property (r.fuse_ok |=> $stable(r.fuses) && r.fuse_ok)
        else $error("fuses changed while running");
    a_cp_decode: assert property (r.fuse_ok && $past(r.fuse_ok)
        |-> code_protect_on == (r.fuses.code_protect_field != CP_DISABLED))
        else $error("protection flag disagrees with field");
    a_powerup_delay_timer_decode: assert property (r.fuse_ok && $past(r.fuse_ok)
        |-> powerup_delay_timer_enabled == !r.fuses.powerup_delay_enable_n)
        else $error("power-up delay flag wrong");
    a_wdt_fuse_off: assert property (ce && !r.wdt_enabled
        |=> r.wdt_cnt == 8'h00 && !wdt_timeout)
        else $error("disabled watchdog still counting");
    a_wdt_expire: assert property (s_wdt_at_limit ##0 r.wdt_cnt == WDT_TICK_LIMIT
        |=> wdt_timeout && r.wdt_cnt == 8'h00)
        else $error("watchdog did not expire at limit");
    a_osc_flags: assert property (r.fuse_ok && $past(r.fuse_ok)
        |-> osc_mode_flags == 4'(4'h1 << r.fuses.osc_mode_select))
        else $error("clock mode flags wrong");
    a_ext_clock: assert property (r.fuse_ok && $past(r.fuse_ok)
        |-> ext_clock_accept == (r.fuses.osc_mode_select != resistor_capacitor_mode))
        else $error("external clock acceptance wrong");

    // ==========================================
    // watchdog and latch checks
    // the count moves only on rc ticks; a clear that meets the last tick
    // wins, so a late clear still keeps the core out of reset
    sequence s_wdt_counting;
        ce && r.wdt_enabled && !wdt_clear && !hold_cpu_reset;
    endsequence
    sequence s_fuses_settled;
        r.fuse_ok && $past(r.fuse_ok);
    endsequence

    a_wdt_count_step: assert property (s_wdt_counting ##0 wdt_rc_tick && r.wdt_cnt != WDT_TICK_LIMIT
        |=> r.wdt_cnt == $past(r.wdt_cnt) + 8'h01 && !wdt_timeout)
        else $error("watchdog missed a tick");

    a_wdt_ignores_clock: assert property (s_wdt_counting ##0 !wdt_rc_tick
        |=> r.wdt_cnt == $past(r.wdt_cnt) && !wdt_timeout)
        else $error("watchdog counted the system clock");

    a_wdt_clear_wins: assert property (ce && wdt_clear |=> r.wdt_cnt == 8'h00 && !wdt_timeout)
        else $error("watchdog clear lost to a tick");

    a_wdt_one_pulse: assert property (ce && wdt_timeout |=> !wdt_timeout)
        else $error("watchdog time-out longer than one cycle");

    a_wdt_reset_hold: assert property (ce && hold_cpu_reset |=> r.wdt_cnt == 8'h00 && !wdt_timeout)
        else $error("watchdog counted while core held in reset");

    // decoded flags are registered on the same edge as the latch; these
    // still wait until both the word and the flags have settled
    a_wdt_decode: assert property (s_fuses_settled |-> wdt_enabled == r.fuses.watchdog_enable_fuse)
        else $error("watchdog enable flag wrong");

    a_mode_one_hot: assert property (s_fuses_settled |-> $onehot(osc_mode_flags))
        else $error("clock mode flags not one-hot");

    a_decode_frozen: assert property (s_fuses_settled |=> $stable({code_protect_on, powerup_delay_timer_enabled, wdt_enabled})
        && $stable({ext_clock_accept, osc_mode_flags}))
        else $error("decoded options moved while running");

    // before the word is read the array stays locked and the strobe is single
    a_cp_locked_early: assert property (!r.fuse_ok |-> code_protect_on)
        else $error("array unlocked before the word was read");

    a_latch_single: assert property (ce && r.fuses_valid |=> !r.fuses_valid)
        else $error("latch strobe repeated");

    a_ready_after_latch: assert property (ce && !r.fuse_ok |=> fuses_ready)
        else $error("word not marked ready after latch");

endmodule
